/* File: design/irs_pkg.sv */
`default_nettype none
package irs_pkg;
    localparam int IRS_NDEV = 5;
    localparam int IRS_NSRC = 6;
    localparam int IRS_ADDR_W = 14;
    // Device slots inside this block.
    localparam int DEV_FLOPPY = 0;
    localparam int DEV_PRINTER = 1;
    localparam int DEV_SER1 = 2;
    localparam int DEV_SER2 = 3;
    localparam int DEV_KBD = 4;
    // Logical device numbers, taken from bus address bits 12:10.
    localparam logic [2:0] DNUM_FLOPPY = 3'h0;
    localparam logic [2:0] DNUM_PRINTER = 3'h3;
    localparam logic [2:0] DNUM_SER1 = 3'h4;
    localparam logic [2:0] DNUM_SER2 = 3'h5;
    localparam logic [2:0] DNUM_KBD = 3'h7;
    localparam int DNUM_LSB = 10;
    localparam int DNUM_MSB = 12;
    localparam int PAGE_BIT = 13;
    localparam int IDX_LSB = 2;
    // Register indices in one device page; the byte offset is four times.
    localparam logic [7:0] OFF_ACTIVATE = 8'h30;
    localparam logic [7:0] OFF_BASE = 8'h60;
    localparam logic [7:0] OFF_IRQ0 = 8'h70;
    localparam logic [7:0] OFF_IRQ1 = 8'h72;
    localparam logic [7:0] OFF_DMA = 8'h74;
    // Reset values.
    localparam logic [3:0] IRQ_RST = 4'h0;
    localparam logic [2:0] DMA_RST = 3'h4;
    localparam logic [11:0] BASE_RST = 12'h000;
    localparam logic ACT_RST = 1'b0;
    // Field widths and limits.
    localparam int IRQ_W = 4;
    localparam int DMA_W = 3;
    localparam logic [2:0] DMA_CH_MIN = 3'h1;
    localparam logic [2:0] DMA_CH_MAX = 3'h3;
    localparam logic [11:0] BASE_MIN = 12'h100;
    localparam logic [11:0] BASE_MAX8 = 12'hff8;
    localparam logic [11:0] BASE_MAX4 = 12'hffc;
    localparam logic [11:0] KBD_DATA_ADDR = 12'h060;
    localparam logic [11:0] KBD_CMD_ADDR = KBD_DATA_ADDR + 12'h004;
    // Which slots implement the optional selection registers.
    localparam logic [4:0] DMA_CAP = 5'b01011;
    localparam logic [4:0] IRQ1_CAP = 5'b10000;
    // Extended control mode codes whose interrupt needs no gate bit, only service mask clear.
    localparam logic [2:0] ECR_FIFO = 3'h2;
    localparam logic [2:0] ECR_ECP = 3'h3;
    localparam logic [2:0] ECR_TEST = 3'h6;
endpackage : irs_pkg
`default_nettype wire

/* File: design/irs_sync.sv */
`default_nettype none
// Pin synchroniser: a bit changes once stages two and three agree.
module irs_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [W-1:0] rst_val,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;
    logic [W-1:0] seen_reg;

    always_comb begin
        q_next = q_reg;
        for (int i = 0; i < W; i++) begin
            if (s2_reg[i] == s3_reg[i] && seen_reg[i]) begin
                q_next[i] = s3_reg[i];
            end
        end
    end

    // The reset value is sampled after release, never under reset.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            q_reg <= '0;
            seen_reg <= '0;
        end else if (ce) begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            seen_reg <= '1;
            q_reg <= (&seen_reg) ? q_next : rst_val;
        end
    end

    assign q = q_reg;
endmodule : irs_sync
`default_nettype wire

/* File: design/irs_router.sv */
// Implementation choice: register access over APB.
`default_nettype none
// What this block does
// - Keyboard is fixed: data at host address 60h, command/status at 64h.
// - Base addresses decode on host address bits 11 down to 0 only.
// - Interrupt level low nibble: 0 none, 1..15 pick IRQ1..IRQ15; reset 0.
// - Routed interrupts are active-high edges, printer ECP/EPP included.
// - Floppy interrupt needs non-zero level and its DMA gate bit set.
// - Printer interrupt needs level and gate; ECP needs mask clear, gate only outside 010,011,110.
// - Serial interrupt needs level, any enable bit 0-3, aux output two.
// - Interrupt pins not selected and used by any device float.
// - DMA select low three bits: 0 reserved, 1..3 channels, 4..7 none.
// - DMA active for 1..3; floppy needs gate, printer ECP needs enable.
// - DMA request pins not selected and used by any device float.
// - A device's own disable bit removes its interrupt and acknowledge.
// - Floppy gate clear or powered down: interrupt and acknowledge off.
// - Serial aux output two clear forces its interrupt to float.
// - Standard and EPP printer: gate bit clear floats the interrupt.
// - ECP: DMA gated by enable; IRQ on for 010,011,110, else gated.
// - Second interrupt select is keyboard only; elsewhere reads zero.
// - DMA select only for floppy, serial two, printer; else zero.
// - Device active by one linked activate/power bit.
module irs_router (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [irs_pkg::IRS_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic floppy_dma_gate,
    input wire logic floppy_powered_down,
    input wire logic printer_irq_gate,
    input wire logic printer_ecp_active,
    input wire logic [2:0] printer_ecr_mode,
    input wire logic ecp_service_mask,
    input wire logic ecp_transfer_gate,
    input wire logic [7:0] uart_irq_enable_reg,
    input wire logic [1:0] aux_output_two_gate,
    input wire logic [irs_pkg::IRS_NSRC-1:0] src_irq,
    input wire logic floppy_dma_request,
    input wire logic printer_dma_request,
    input wire logic serial2_dma_request,
    input wire logic [11:0] io_addr,
    input wire logic [3:1] dma_ack_n,
    output logic [15:1] irq_out,
    output logic [15:1] irq_oe,
    output logic [3:1] dma_request_pins,
    output logic [3:1] dma_request_oe,
    output logic floppy_dack,
    output logic printer_dack,
    output logic serial2_dack,
    output logic [irs_pkg::IRS_NDEV-1:0] io_hit
);
    import irs_pkg::*;

    logic act_reg [IRS_NDEV];
    logic act_next [IRS_NDEV];
    logic [11:0] base_reg [IRS_NDEV];
    logic [11:0] base_next [IRS_NDEV];
    logic [IRQ_W-1:0] lvl0_reg [IRS_NDEV];
    logic [IRQ_W-1:0] lvl0_next [IRS_NDEV];
    logic [IRQ_W-1:0] kbd_lvl1_reg;
    logic [IRQ_W-1:0] kbd_lvl1_next;
    logic [DMA_W-1:0] dma_reg [IRS_NDEV];
    logic [DMA_W-1:0] dma_next [IRS_NDEV];
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic err_reg;
    logic err_next;
    logic ld_reg;
    logic ld_next;

    logic [2:0] dsel;
    logic dvalid;
    logic [7:0] roff;
    logic [2:0] slot;
    logic wr_go;
    logic [11:0] io_s;
    logic [3:1] ack_n_s;

    // Bus decode: page bit 13 clear, device number in bits 12:10.
    always_comb begin
        dsel = paddr[DNUM_MSB:DNUM_LSB];
        roff = paddr[IDX_LSB+7:IDX_LSB];
        dvalid = !paddr[PAGE_BIT];
        slot = 3'(DEV_FLOPPY);
        case (dsel)
            DNUM_FLOPPY: slot = 3'(DEV_FLOPPY);
            DNUM_PRINTER: slot = 3'(DEV_PRINTER);
            DNUM_SER1: slot = 3'(DEV_SER1);
            DNUM_SER2: slot = 3'(DEV_SER2);
            DNUM_KBD: slot = 3'(DEV_KBD);
            default: dvalid = 1'b0;
        endcase
    end

    // Read data is fetched on the first enabled cycle of a transfer; ready
    // waits for ce so a frozen cycle never completes a write that is lost.
    assign pready = psel && penable && ld_reg && ce;
    assign wr_go = pready && pwrite && !err_reg;
    assign prdata = prdata_reg;
    assign pslverr = pready && err_reg;

    always_comb begin
        prdata_next = prdata_reg;
        err_next = err_reg;
        ld_next = ld_reg;
        if (!psel || pready) begin
            ld_next = 1'b0;
        end else begin
            ld_next = 1'b1;
            prdata_next = '0;
            err_next = !dvalid || (paddr[1:0] != 2'b00);
            if (!err_next && !pwrite) begin
                case (roff)
                    OFF_ACTIVATE: prdata_next[0] = act_reg[slot];
                    OFF_BASE: prdata_next[11:0] = base_reg[slot];
                    OFF_IRQ0: prdata_next[IRQ_W-1:0] = lvl0_reg[slot];
                    OFF_IRQ1: begin
                        if (IRQ1_CAP[slot]) begin
                            prdata_next[IRQ_W-1:0] = kbd_lvl1_reg;
                        end
                    end
                    OFF_DMA: begin
                        if (DMA_CAP[slot]) begin
                            prdata_next[DMA_W-1:0] = dma_reg[slot];
                        end
                    end
                    default: prdata_next = '0;
                endcase
            end
        end
    end

    always_comb begin
        for (int d = 0; d < IRS_NDEV; d++) begin
            act_next[d] = act_reg[d];
            base_next[d] = base_reg[d];
            lvl0_next[d] = lvl0_reg[d];
            dma_next[d] = dma_reg[d];
        end
        kbd_lvl1_next = kbd_lvl1_reg;
        if (wr_go && dvalid) begin
            case (roff)
                // One flop serves as both activate and power bit.
                OFF_ACTIVATE: act_next[slot] = pwdata[0];
                OFF_BASE: begin
                    if (slot != 3'(DEV_KBD)) begin
                        base_next[slot] = pwdata[11:0];
                    end
                end
                OFF_IRQ0: lvl0_next[slot] = pwdata[IRQ_W-1:0];
                OFF_IRQ1: begin
                    if (IRQ1_CAP[slot]) begin
                        kbd_lvl1_next = pwdata[IRQ_W-1:0];
                    end
                end
                OFF_DMA: begin
                    if (DMA_CAP[slot]) begin
                        dma_next[slot] = pwdata[DMA_W-1:0];
                    end
                end
                default: kbd_lvl1_next = kbd_lvl1_reg;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (int d = 0; d < IRS_NDEV; d++) begin
                act_reg[d] <= ACT_RST;
                base_reg[d] <= BASE_RST;
                lvl0_reg[d] <= IRQ_RST;
                dma_reg[d] <= DMA_RST;
            end
            kbd_lvl1_reg <= IRQ_RST;
            prdata_reg <= '0;
            err_reg <= 1'b0;
            ld_reg <= 1'b0;
        end else if (ce) begin
            for (int d = 0; d < IRS_NDEV; d++) begin
                act_reg[d] <= act_next[d];
                base_reg[d] <= base_next[d];
                lvl0_reg[d] <= lvl0_next[d];
                dma_reg[d] <= dma_next[d];
            end
            kbd_lvl1_reg <= kbd_lvl1_next;
            prdata_reg <= prdata_next;
            err_reg <= err_next;
            ld_reg <= ld_next;
        end
    end

    irs_sync #(.W(12)) u_io_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .ce(ce),
        .rst_val(12'h000),
        .d(io_addr),
        .q(io_s)
    );

    irs_sync #(.W(3)) u_ack_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .ce(ce),
        .rst_val(3'h7),
        .d(dma_ack_n),
        .q(ack_n_s)
    );

    // Device enables, address decode and gating per device slot.
    logic [IRS_NDEV-1:0] dev_ok;
    logic [IRS_NDEV-1:0] hit_next;
    logic [IRS_NDEV-1:0] dma_on;
    logic [IRS_NDEV-1:0] dma_gate;
    logic [IRS_NSRC-1:0] irq_on;
    logic [IRS_NSRC-1:0] irq_gate;
    logic [IRQ_W-1:0] src_lvl [IRS_NSRC];
    logic ecp_irq_free;

    assign ecp_irq_free = (printer_ecr_mode == ECR_FIFO) ||
                          (printer_ecr_mode == ECR_ECP) ||
                          (printer_ecr_mode == ECR_TEST);

    // Floppy gate off or powered down silences interrupt and acknowledge.
    assign irq_gate[DEV_FLOPPY] = floppy_dma_gate &&
                                  !floppy_powered_down;
    assign irq_gate[DEV_PRINTER] = printer_ecp_active ?
        ((ecp_irq_free || printer_irq_gate) && !ecp_service_mask) :
        printer_irq_gate;
    assign irq_gate[DEV_SER1] = (|uart_irq_enable_reg[3:0]) &&
                                aux_output_two_gate[0];
    assign irq_gate[DEV_SER2] = (|uart_irq_enable_reg[7:4]) &&
                                aux_output_two_gate[1];
    assign irq_gate[DEV_KBD] = 1'b1;
    assign irq_gate[DEV_KBD+1] = 1'b1;

    assign dma_gate[DEV_FLOPPY] = floppy_dma_gate &&
                                  !floppy_powered_down;
    assign dma_gate[DEV_PRINTER] = ecp_transfer_gate;
    assign dma_gate[DEV_SER1] = 1'b0;
    assign dma_gate[DEV_SER2] = 1'b1;
    assign dma_gate[DEV_KBD] = 1'b0;

    genvar g;
    generate
        for (g = 0; g < IRS_NDEV; g++) begin : g_dev
            logic bok;
            logic [11:0] amask;
            if (g == DEV_KBD) begin : g_fix
                assign bok = 1'b1;
                assign amask = 12'hfff;
                assign hit_next[g] = act_reg[g] &&
                    (io_s == KBD_DATA_ADDR || io_s == KBD_CMD_ADDR);
            end else begin : g_rel
                // Printer may sit on 4-byte bounds, all others on 8.
                assign amask = (g == DEV_PRINTER) ? 12'hffc : 12'hff8;
                assign bok = (base_reg[g] >= BASE_MIN) &&
                    (base_reg[g] <= ((g == DEV_PRINTER) ? BASE_MAX4 :
                    BASE_MAX8)) && ((base_reg[g] & ~amask) == 12'h000);
                assign hit_next[g] = dev_ok[g] &&
                    ((io_s & amask) == base_reg[g]);
            end
            assign dev_ok[g] = act_reg[g] && bok;
            assign dma_on[g] = DMA_CAP[g] && dev_ok[g] && dma_gate[g] &&
                (dma_reg[g] >= DMA_CH_MIN) &&
                (dma_reg[g] <= DMA_CH_MAX);
        end
        for (g = 0; g < IRS_NSRC; g++) begin : g_src
            localparam int DV = (g > DEV_KBD) ? DEV_KBD : g;
            assign src_lvl[g] = (g > DEV_KBD) ? kbd_lvl1_reg : lvl0_reg[DV];
            assign irq_on[g] = dev_ok[DV] && irq_gate[g] &&
                (src_lvl[g] != IRQ_RST);
        end
    endgenerate

    // Pin drive: a pin is enabled only while some enabled source owns it.
    logic [15:1] irq_out_next;
    logic [15:1] irq_oe_next;
    logic [15:1] irq_out_reg;
    logic [15:1] irq_oe_reg;
    logic [3:1] drq_next;
    logic [3:1] drq_oe_next;
    logic [3:1] drq_reg;
    logic [3:1] drq_oe_reg;
    logic [2:0] dreq;
    logic [2:0] dack_next;
    logic [2:0] dack_reg;
    logic [IRS_NDEV-1:0] hit_reg;

    assign dreq = {serial2_dma_request, printer_dma_request,
                   floppy_dma_request};

    always_comb begin
        irq_out_next = '0;
        irq_oe_next = '0;
        drq_next = '0;
        drq_oe_next = '0;
        dack_next = '0;
        for (int p = 1; p < 16; p++) begin
            for (int s = 0; s < IRS_NSRC; s++) begin
                if (irq_on[s] && src_lvl[s] == IRQ_W'(p)) begin
                    irq_oe_next[p] = 1'b1;
                    // Active-high level; its rising edge is the request.
                    irq_out_next[p] = irq_out_next[p] | src_irq[s];
                end
            end
        end
        for (int c = 1; c < 4; c++) begin
            for (int k = 0; k < 3; k++) begin
                // Slots with DMA are floppy, printer and serial two.
                if (dma_on[(k == 2) ? DEV_SER2 : k] &&
                    dma_reg[(k == 2) ? DEV_SER2 : k] == DMA_W'(c)) begin
                    drq_oe_next[c] = 1'b1;
                    drq_next[c] = drq_next[c] | dreq[k];
                    dack_next[k] = dack_next[k] | !ack_n_s[c];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            irq_out_reg <= '0;
            irq_oe_reg <= '0;
            drq_reg <= '0;
            drq_oe_reg <= '0;
            dack_reg <= '0;
            hit_reg <= '0;
        end else if (ce) begin
            irq_out_reg <= irq_out_next;
            irq_oe_reg <= irq_oe_next;
            drq_reg <= drq_next;
            drq_oe_reg <= drq_oe_next;
            dack_reg <= dack_next;
            hit_reg <= hit_next;
        end
    end

    assign irq_out = irq_out_reg;
    assign irq_oe = irq_oe_reg;
    assign dma_request_pins = drq_reg;
    assign dma_request_oe = drq_oe_reg;
    assign floppy_dack = dack_reg[0];
    assign printer_dack = dack_reg[1];
    assign serial2_dack = dack_reg[2];
    assign io_hit = hit_reg;
endmodule : irs_router
`default_nettype wire

/* File: tb/irs_router_assertions.sv */
`default_nettype none
module irs_router_assertions (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [irs_pkg::IRS_ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic floppy_dma_gate,
    input wire logic floppy_powered_down,
    input wire logic ecp_transfer_gate,
    input wire logic [15:1] irq_oe,
    input wire logic [3:1] dma_request_oe,
    input wire logic floppy_dack,
    input wire logic printer_dack
);
    import irs_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    a_zero_wait: assert property (ce && psel && !penable ##1 ce |-> pready)
        else $error("access phase did not complete at once");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_err_page: assert property (pready && paddr[PAGE_BIT] |-> pslverr)
        else $error("upper page accepted");
    a_err_align: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned address accepted");
    a_err_data: assert property (pready && pslverr && !pwrite |-> prdata == 0)
        else $error("refused read returned data");
    a_reset_quiet: assert property ($rose(nrst) |-> irq_oe == 15'h0
        && dma_request_oe == 3'h0)
        else $error("pins driven right after reset");
    a_floppy_gate: assert property (ce && !floppy_dma_gate
        |=> !floppy_dack)
        else $error("floppy acknowledge with gate clear");
    a_floppy_pwr: assert property (ce && floppy_powered_down
        |=> !floppy_dack)
        else $error("floppy acknowledge while powered down");
    a_printer_dma: assert property (ce && !ecp_transfer_gate
        |=> !printer_dack)
        else $error("printer acknowledge with transfer gate clear");
endmodule : irs_router_assertions
`default_nettype wire

/* File: tb/irs_host_model.sv */
`default_nettype none
module irs_host_model (
    input wire logic clk_sys,
    input wire logic slow,
    input wire logic [15:1] irq_out,
    input wire logic [15:1] irq_oe,
    input wire logic [3:1] dma_request_pins,
    input wire logic [3:1] dma_request_oe,
    output wire logic [15:1] irq_line,
    output wire logic [3:1] drq_line,
    output logic [3:1] dma_ack_n
);
    timeunit 1ns;
    timeprecision 100ps;
    int wait_cnt [3:1];
    // Released pins stay at z so a float is never mistaken for a level.
    for (genvar i = 1; i < 16; i++) begin : g_irq
        assign irq_line[i] = irq_oe[i] ? irq_out[i] : 1'bz;
    end
    for (genvar i = 1; i < 4; i++) begin : g_drq
        assign drq_line[i] = dma_request_oe[i] ? dma_request_pins[i] : 1'bz;
    end
    initial dma_ack_n = 3'h7;
    always @(posedge clk_sys) begin
        for (int c = 1; c < 4; c++) begin
            if (drq_line[c] !== 1'b1) begin
                wait_cnt[c] <= 0;
                dma_ack_n[c] <= 1'b1;
            end else if (wait_cnt[c] >= (slow ? 6 : 1)) begin
                dma_ack_n[c] <= 1'b0;
            end else begin
                wait_cnt[c] <= wait_cnt[c] + 1;
            end
        end
    end
endmodule : irs_host_model
`default_nettype wire

/* File: tb/irs_router_test.sv */
`default_nettype none
module irs_router_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys, nrst, ce, psel, penable, pwrite, pready, pslverr, errv;
    logic fgate, fpd, pgate, pecp, smask, tgate, freq, preq, ack_slow;
    logic fdack, pdack, sdack;
    logic [11:0] io_addr;
    logic [irs_pkg::IRS_ADDR_W-1:0] paddr;
    logic [1:0] lowb;
    logic sreq;
    logic [31:0] pwdata, prdata, rdv;
    logic [2:0] ecr;
    logic [7:0] uier;
    logic [1:0] aux;
    logic [5:0] src;
    logic [4:0] hit;
    logic [3:1] ack_n, drq, drq_oe;
    logic [15:1] irq_o, irq_oe;
    wire logic [15:1] irq_line;
    wire logic [3:1] drq_line;
    int err_total, compares;
    irs_router irs_router_inst (.clk_sys(clk_sys), .nrst(nrst), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .floppy_dma_gate(fgate),
        .floppy_powered_down(fpd), .printer_irq_gate(pgate),
        .printer_ecp_active(pecp), .printer_ecr_mode(ecr),
        .ecp_service_mask(smask), .ecp_transfer_gate(tgate),
        .uart_irq_enable_reg(uier), .aux_output_two_gate(aux),
        .src_irq(src), .floppy_dma_request(freq),
        .printer_dma_request(preq), .serial2_dma_request(sreq),
        .io_addr(io_addr), .dma_ack_n(ack_n), .irq_out(irq_o),
        .irq_oe(irq_oe), .dma_request_pins(drq), .dma_request_oe(drq_oe),
        .floppy_dack(fdack), .printer_dack(pdack), .serial2_dack(sdack),
        .io_hit(hit));
    irs_host_model irs_host_model_inst (.clk_sys(clk_sys), .slow(ack_slow),
        .irq_out(irq_o), .irq_oe(irq_oe), .dma_request_pins(drq),
        .dma_request_oe(drq_oe), .irq_line(irq_line), .drq_line(drq_line),
        .dma_ack_n(ack_n));
    task automatic summarize();
        if (err_total == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {a, lowb};
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb
    task automatic rchk(input logic [11:0] a, input logic [31:0] e,
            input logic ee);
        apb(1'b0, a, 32'h0);
        chk(rdv, e);
        chk({31'h0, errv}, {31'h0, ee});
    endtask : rchk
    // Expected pin vector: line i high, every other line floating.
    function automatic logic [31:0] one(input int i, input int w);
        logic [31:0] v;
        v = 32'h0;
        for (int j = 1; j <= w; j++) v[j] = (j == i) ? 1'b1 : 1'bz;
        return v;
    endfunction : one
    task automatic iq(input int i);
        tick(3);
        chk({16'h0, irq_line, 1'b0}, one(i, 15));
    endtask : iq
    task automatic dq(input int i);
        tick(3);
        chk({28'h0, drq_line, 1'b0}, one(i, 3));
    endtask : dq
    task automatic hq(input logic [11:0] a, input logic [4:0] e);
        io_addr <= a;
        tick(8);
        chk({27'h0, hit}, {27'h0, e});
    endtask : hq
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        summarize();
    end
    initial begin
        err_total = 0;
        compares = 0;
        {nrst, psel, penable, pwrite, fgate, fpd, pgate, pecp} = '0;
        {smask, tgate, freq, preq, ack_slow, sreq} = '0;
        {paddr, io_addr, pwdata, ecr, uier, aux, src, lowb} = '0;
        ce = 1'b1;
        tick(2);
        nrst <= 1'b1;
        tick(1);
        rchk(12'h070, 32'h0, 1'b0);
        rchk(12'h074, 32'h4, 1'b0);
        apb(1'b1, 12'h072, 32'h5);
        rchk(12'h072, 32'h0, 1'b0);
        apb(1'b1, 12'h772, 32'h5a);
        rchk(12'h772, 32'ha, 1'b0);
        apb(1'b1, 12'h474, 32'h2);
        rchk(12'h474, 32'h0, 1'b0);
        rchk(12'h870, 32'h0, 1'b1);
        rchk(12'h170, 32'h0, 1'b1);
        lowb = 2'h1;
        rchk(12'h070, 32'h0, 1'b1);
        apb(1'b1, 12'h070, 32'h9);
        lowb = 2'h0;
        rchk(12'h070, 32'h0, 1'b0);
        apb(1'b1, 12'h030, 32'h1);
        apb(1'b1, 12'h060, 32'h3f0);
        apb(1'b1, 12'h074, 32'hfa);
        rchk(12'h074, 32'h2, 1'b0);
        apb(1'b1, 12'h070, 32'h6);
        src <= 6'h3f;
        iq(0);
        dq(0);
        fgate <= 1'b1;
        freq <= 1'b1;
        for (int i = 1; i < 16; i++) begin
            apb(1'b1, 12'h070, 32'(i));
            iq(i);
        end
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, 12'h074, 32'(i));
            dq((i >= 1 && i <= 3) ? i : 0);
        end
        apb(1'b1, 12'h074, 32'h2);
        tick(12);
        chk({31'h0, fdack}, 32'h1);
        src[0] <= 1'b0;
        tick(3);
        chk({31'h0, irq_line[15]}, 32'h0);
        src[0] <= 1'b1;
        fpd <= 1'b1;
        iq(0);
        chk({31'h0, fdack}, 32'h0);
        fpd <= 1'b0;
        fgate <= 1'b0;
        dq(0);
        fgate <= 1'b1;
        apb(1'b1, 12'h030, 32'h0);
        iq(0);
        apb(1'b1, 12'h070, 32'h0);
        apb(1'b1, 12'h430, 32'h1);
        apb(1'b1, 12'h460, 32'h3f8);
        apb(1'b1, 12'h470, 32'h4);
        aux <= 2'h1;
        iq(0);
        uier <= 8'h80;
        iq(0);
        uier <= 8'h08;
        iq(4);
        aux <= 2'h2;
        iq(0);
        apb(1'b1, 12'h470, 32'h0);
        apb(1'b1, 12'h530, 32'h1);
        apb(1'b1, 12'h560, 32'h2f8);
        apb(1'b1, 12'h574, 32'h1);
        sreq <= 1'b1;
        dq(1);
        tick(12);
        chk({31'h0, sdack}, 32'h1);
        apb(1'b1, 12'h530, 32'h0);
        dq(0);
        apb(1'b1, 12'h330, 32'h1);
        apb(1'b1, 12'h360, 32'h378);
        apb(1'b1, 12'h370, 32'h7);
        iq(0);
        pgate <= 1'b1;
        iq(7);
        ce <= 1'b0;
        src[1] <= 1'b0;
        tick(3);
        chk({31'h0, irq_line[7]}, 32'h1);
        ce <= 1'b1;
        src[1] <= 1'b1;
        pecp <= 1'b1;
        pgate <= 1'b0;
        for (int m = 0; m < 8; m++) begin
            ecr <= 3'(m);
            iq((m == 2 || m == 3 || m == 6) ? 7 : 0);
        end
        ecr <= 3'h2;
        smask <= 1'b1;
        iq(0);
        apb(1'b1, 12'h374, 32'h3);
        preq <= 1'b1;
        ack_slow <= 1'b1;
        dq(0);
        tgate <= 1'b1;
        dq(3);
        tick(20);
        chk({31'h0, pdack}, 32'h1);
        apb(1'b1, 12'h730, 32'h1);
        hq(12'h060, 5'h10);
        hq(12'h064, 5'h10);
        hq(12'h3f8, 5'h04);
        hq(12'h37a, 5'h02);
        summarize();
    end
endmodule : irs_router_test
bind irs_router irs_router_assertions irs_router_assertions_inst (
    .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .floppy_dma_gate(floppy_dma_gate),
    .floppy_powered_down(floppy_powered_down),
    .ecp_transfer_gate(ecp_transfer_gate), .irq_oe(irq_oe),
    .dma_request_oe(dma_request_oe), .floppy_dack(floppy_dack),
    .printer_dack(printer_dack));
`default_nettype wire
